/* File: verilog/atio_pkg.sv */
package atio_pkg;
	// Register offsets on the plain port (byte addresses)
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STROBE  = 4'h4;
	localparam logic [3:0] ADDR_STATUS  = 4'h8;
	localparam logic [3:0] ADDR_CONVCNT = 4'hC;

	// Control register field positions
	localparam int CTRL_MODE_BIT  = 0;
	localparam int CTRL_ARM_BIT   = 1;
	localparam int CTRL_SCAN_BIT  = 2;
	localparam int CTRL_SENSE_BIT = 3;
	localparam int CTRL_SWCONV_BIT = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Timing
	localparam int CLK_PERIOD_NS   = 40;
	localparam int STROBE_MIN_NS   = 200;
	localparam int STROBE_CYCLES   =
		(STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCAN_PULSE_NS   = 80;
	localparam int SCAN_PULSE_CYCLES =
		(SCAN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Acquisition sequence states
	typedef enum logic [1:0] {
		ATIO_IDLE,
		ATIO_ARMED,
		ATIO_PRE,
		ATIO_POST
	} atio_state_t;

	// Synchronised edge and level events from the connector
	typedef struct packed {
		logic begin_rise;
		logic halt_fall;
		logic conv_fall;
		logic gate_low;
		logic conv_low;
	} atio_events_t;
endpackage

/* File: verilog/atio_edge_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser with rise and fall detect on the settled level
module atio_edge_sync
#(
	parameter logic IDLE_LEVEL = 1'b1
)
(
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic async_in,
	output logic      level_ff,
	output logic      rise,
	output logic      fall
);
	logic meta_ff;
	logic prev_ff;

	// First stage is read only by the second stage; reset loads the
	// pin's idle level so leaving reset never fakes an edge
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			meta_ff  <= IDLE_LEVEL;
			level_ff <= IDLE_LEVEL;
			prev_ff  <= IDLE_LEVEL;
		end
		else
		begin
			meta_ff  <= async_in;
			level_ff <= meta_ff;
			prev_ff  <= level_ff;
		end
	end

	// Edges are one cycle pulses, so each edge acts once
	assign rise = level_ff & ~prev_ff;
	assign fall = ~level_ff & prev_ff;
endmodule

/* File: verilog/atio_timing_io.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - One conversion pulse per scanned conversion
// - Pulse rising edge marks sample taken
// - Strobe write gives low pulse, 200ns min
// - Posttrigger: begin rising edge starts sequence
// - Pretrigger: begin rising edge starts preconversions
// - Pretrigger: halt falling edge starts posttrigger
// - Conversion request falling edge converts once
// - Gate or request low inhibits conversions
// - Sense reference drivable from analog ground
module atio_timing_io
#(
	parameter int CONV_CNT_W = 16
)
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata_ff,
	input  wire logic        acq_begin_trig_n,
	input  wire logic        acq_halt_trig,
	input  wire logic        conv_request_n,
	input  wire logic        conv_gate_n,
	input  wire logic        adc_done,
	output logic             conv_start_ff,
	output logic             conv_pulse_out_ff,
	output logic             user_strobe_n_ff,
	output logic             sense_to_ground_ff,
	output logic             acq_active_ff,
	output logic             acq_post_ff
);
	atio_pkg::atio_events_t ev;
	atio_pkg::atio_state_t  state_ff;
	atio_pkg::atio_state_t  nxt_state;
	logic [7:0]             ctrl_ff;
	logic [2:0]             strobe_cnt_ff;
	logic [2:0]             scan_cnt_ff;
	logic [CONV_CNT_W-1:0]  conv_cnt_ff;
	logic                   conv_busy_ff;
	logic                   begin_lvl;
	logic                   halt_lvl;
	logic                   conv_lvl;
	logic                   gate_lvl;
	logic                   conv_ok;
	logic                   arm_pulse;
	logic                   sw_conv;

	// All checks run on ref_clk and stand down while reset is high
	default clocking cb_atio @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	// Connector inputs cross into ref_clk before any edge logic
	atio_edge_sync u_begin
	(
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in (acq_begin_trig_n),
		.level_ff (begin_lvl),
		.rise     (ev.begin_rise),
		.fall     ()
	);
	atio_edge_sync #(.IDLE_LEVEL(1'b0)) u_halt
	(
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in (acq_halt_trig),
		.level_ff (halt_lvl),
		.rise     (),
		.fall     (ev.halt_fall)
	);
	atio_edge_sync u_conv
	(
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in (conv_request_n),
		.level_ff (conv_lvl),
		.rise     (),
		.fall     (ev.conv_fall)
	);
	atio_edge_sync u_gate
	(
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in (conv_gate_n),
		.level_ff (gate_lvl),
		.rise     (),
		.fall     ()
	);

	assign ev.gate_low  = ~gate_lvl;
	assign ev.conv_low  = ~conv_lvl;

	// Register decode strobes
	assign arm_pulse = reg_wr && reg_addr == atio_pkg::ADDR_CTRL
		&& reg_wdata[atio_pkg::CTRL_ARM_BIT];
	assign sw_conv = reg_wr && reg_addr == atio_pkg::ADDR_CTRL
		&& reg_wdata[atio_pkg::CTRL_SWCONV_BIT];

	// A request edge converts unless gated; a request held low also
	// blocks software converts, so only the edge itself gets through
	assign conv_ok = (ev.conv_fall || (sw_conv && !ev.conv_low))
		&& !ev.gate_low && !conv_busy_ff
		&& (state_ff == atio_pkg::ATIO_PRE
		|| state_ff == atio_pkg::ATIO_POST);

	// Control register; arm and software convert bits self-clear
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			ctrl_ff <= atio_pkg::CTRL_RESET;
		else if (reg_wr && reg_addr == atio_pkg::ADDR_CTRL)
		begin
			ctrl_ff    <= reg_wdata[7:0];
			ctrl_ff[atio_pkg::CTRL_ARM_BIT]   <= 1'b0;
			ctrl_ff[atio_pkg::CTRL_SWCONV_BIT] <= 1'b0;
		end
	end

	// Sense node drive follows the program bit
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			sense_to_ground_ff <= 1'b0;
		else
			sense_to_ground_ff <= ctrl_ff[atio_pkg::CTRL_SENSE_BIT];
	end

	// Sequence state: mode bit 1 is pretrigger
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			atio_pkg::ATIO_IDLE:
				if (arm_pulse)
					nxt_state = atio_pkg::ATIO_ARMED;
			atio_pkg::ATIO_ARMED:
				if (ev.begin_rise)
				begin
					if (ctrl_ff[atio_pkg::CTRL_MODE_BIT])
						nxt_state = atio_pkg::ATIO_PRE;
					else
						nxt_state = atio_pkg::ATIO_POST;
				end
			atio_pkg::ATIO_PRE:
				if (ev.halt_fall)
					nxt_state = atio_pkg::ATIO_POST;
			atio_pkg::ATIO_POST:
				if (reg_wr && reg_addr == atio_pkg::ADDR_CTRL
					&& !reg_wdata[atio_pkg::CTRL_ARM_BIT])
					nxt_state = atio_pkg::ATIO_IDLE;
			default:
				nxt_state = atio_pkg::ATIO_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			state_ff <= atio_pkg::ATIO_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Status outputs for the sequencer
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			acq_active_ff <= 1'b0;
			acq_post_ff   <= 1'b0;
		end
		else
		begin
			acq_active_ff <= nxt_state == atio_pkg::ATIO_PRE
				|| nxt_state == atio_pkg::ATIO_POST;
			acq_post_ff   <= nxt_state == atio_pkg::ATIO_POST;
		end
	end

	// Conversion start and busy until the converter reports done
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			conv_start_ff <= 1'b0;
			conv_busy_ff  <= 1'b0;
		end
		else
		begin
			conv_start_ff <= conv_ok;
			if (conv_ok)
				conv_busy_ff <= 1'b1;
			else if (adc_done)
				conv_busy_ff <= 1'b0;
		end
	end

	// Scan pulse rises at done, falls after SCAN_PULSE_CYCLES high cycles
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			conv_pulse_out_ff <= 1'b0;
			scan_cnt_ff       <= 3'h0;
		end
		else if (conv_busy_ff && adc_done
			&& ctrl_ff[atio_pkg::CTRL_SCAN_BIT])
		begin
			conv_pulse_out_ff <= 1'b1;
			scan_cnt_ff       <= 3'(atio_pkg::SCAN_PULSE_CYCLES - 1);
		end
		else if (scan_cnt_ff != 3'h0)
			scan_cnt_ff <= scan_cnt_ff - 3'h1;
		else
			conv_pulse_out_ff <= 1'b0;
	end

	// Count of conversions started, cleared on arm, readable by software
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			conv_cnt_ff <= '0;
		else if (arm_pulse)
			conv_cnt_ff <= '0;
		else if (conv_ok)
			conv_cnt_ff <= conv_cnt_ff + 1'b1;
	end

	// Strobe write: low for the rounded-up minimum; a rewrite restarts
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			user_strobe_n_ff <= 1'b1;
			strobe_cnt_ff    <= 3'h0;
		end
		else if (reg_wr && reg_addr == atio_pkg::ADDR_STROBE)
		begin
			user_strobe_n_ff <= 1'b0;
			strobe_cnt_ff    <= 3'(atio_pkg::STROBE_CYCLES - 1);
		end
		else if (strobe_cnt_ff != 3'h0)
			strobe_cnt_ff <= strobe_cnt_ff - 3'h1;
		else
			user_strobe_n_ff <= 1'b1;
	end

	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			reg_rdata_ff <= 32'h0;
		else if (reg_rd)
			case (reg_addr)
				atio_pkg::ADDR_CTRL:
					reg_rdata_ff <= {24'h0, ctrl_ff};
				atio_pkg::ADDR_STATUS:
					reg_rdata_ff <= {24'h0, acq_post_ff, acq_active_ff,
						conv_busy_ff, ~halt_lvl, begin_lvl, ev.gate_low,
						ev.conv_low, user_strobe_n_ff};
				atio_pkg::ADDR_CONVCNT:
					reg_rdata_ff <= 32'(conv_cnt_ff);
				default:
					reg_rdata_ff <= 32'h0;
			endcase
		else
			reg_rdata_ff <= 32'h0;
	end

	// Strobe stays low for at least the minimum count
	property p_strobe_width;
		$fell(user_strobe_n_ff) |-> !user_strobe_n_ff [*5];
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("strobe pulse too short");
	// Strobe follows a strobe write in one cycle
	property p_strobe_start;
		reg_wr && reg_addr == atio_pkg::ADDR_STROBE
			|=> !user_strobe_n_ff;
	endproperty
	a_strobe_start: assert property (p_strobe_start)
		else $error("strobe did not start");
	// Posttrigger launch on begin edge
	property p_post_launch;
		state_ff == atio_pkg::ATIO_ARMED && ev.begin_rise
			&& !ctrl_ff[atio_pkg::CTRL_MODE_BIT]
			|=> state_ff == atio_pkg::ATIO_POST ##1 acq_post_ff;
	endproperty
	a_post_launch: assert property (p_post_launch)
		else $error("posttrigger did not launch");
	// Pretrigger start on begin edge
	property p_pre_launch;
		state_ff == atio_pkg::ATIO_ARMED && ev.begin_rise
			&& ctrl_ff[atio_pkg::CTRL_MODE_BIT]
			|=> state_ff == atio_pkg::ATIO_PRE;
	endproperty
	a_pre_launch: assert property (p_pre_launch)
		else $error("pretrigger did not start");
	// Halt edge moves pretrigger into posttrigger
	property p_halt;
		state_ff == atio_pkg::ATIO_PRE && ev.halt_fall
			|=> state_ff == atio_pkg::ATIO_POST;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt edge ignored");
	// Request edge in an active sequence converts
	property p_conv;
		ev.conv_fall && !ev.gate_low && !conv_busy_ff && acq_active_ff
			&& state_ff != atio_pkg::ATIO_ARMED |=> conv_start_ff;
	endproperty
	a_conv: assert property (p_conv)
		else $error("conversion not started");
	// Gate low suppresses conversions
	property p_gate;
		ev.gate_low |=> !conv_start_ff;
	endproperty
	a_gate: assert property (p_gate)
		else $error("conversion while gated");
	// Each finished scanned conversion pulses once
	property p_scan;
		conv_busy_ff && adc_done && ctrl_ff[atio_pkg::CTRL_SCAN_BIT]
			|=> conv_pulse_out_ff [*2] ##1 !conv_pulse_out_ff;
	endproperty
	a_scan: assert property (p_scan)
		else $error("scan pulse wrong");
	// Sense drive follows its bit a cycle later
	property p_sense;
		##1 sense_to_ground_ff == $past(ctrl_ff[atio_pkg::CTRL_SENSE_BIT]);
	endproperty
	a_sense: assert property (p_sense)
		else $error("sense drive mismatch");
endmodule

/* File: testbench/atio_fixture.sv */
`timescale 1ns/1ps
// External trigger fixture; every line rests at its inactive level
module atio_fixture
(
	input  wire logic ref_clk,
	output logic      begin_trig_n,
	output logic      halt_trig,
	output logic      req_n,
	output logic      gate_n
);
	// Idle levels: nothing asserted
	initial
	begin
		begin_trig_n = 1'b1;
		halt_trig    = 1'b0;
		req_n        = 1'b1;
		gate_n       = 1'b1;
	end

	// Change one line after an edge, then hold it three cycles so the
	// synchroniser sees it twice even when the first sample is marginal
	task automatic drive(input int s, input logic v);
		@(posedge ref_clk);
		case (s)
			0: begin_trig_n <= v;
			1: halt_trig    <= v;
			2: req_n        <= v;
			default: gate_n <= v;
		endcase
		repeat (3) @(posedge ref_clk);
	endtask
endmodule

/* File: testbench/tb_acquisition_trigger_timing_io.sv */
`timescale 1ns/1ps
module tb_acquisition_trigger_timing_io;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        adc_done = 1'b0;
	logic [31:0] reg_rdata_ff;
	logic        begin_n;
	logic        halt;
	logic        req_n;
	logic        gate_n;
	logic        conv_start_ff;
	logic        conv_pulse_out_ff;
	logic        user_strobe_n_ff;
	logic        sense_to_ground_ff;
	logic        acq_active_ff;
	logic        acq_post_ff;
	logic [2:0]  mon;
	logic [1:0]  busy_ff = 2'h0;
	logic        scan_d_ff = 1'b0;
	int          n_conv = 0;
	int          n_scan = 0;
	int          miscompares = 0;
	int          samples_checked = 0;

	// Clock at 25 MHz
	always #20 ref_clk = ~ref_clk;

	assign mon = {conv_pulse_out_ff, acq_post_ff, acq_active_ff};

	atio_timing_io dut
	(
		.ref_clk            (ref_clk),
		.reset              (reset),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata_ff       (reg_rdata_ff),
		.acq_begin_trig_n   (begin_n),
		.acq_halt_trig      (halt),
		.conv_request_n     (req_n),
		.conv_gate_n        (gate_n),
		.adc_done           (adc_done),
		.conv_start_ff      (conv_start_ff),
		.conv_pulse_out_ff  (conv_pulse_out_ff),
		.user_strobe_n_ff   (user_strobe_n_ff),
		.sense_to_ground_ff (sense_to_ground_ff),
		.acq_active_ff      (acq_active_ff),
		.acq_post_ff        (acq_post_ff)
	);

	atio_fixture fx
	(
		.ref_clk      (ref_clk),
		.begin_trig_n (begin_n),
		.halt_trig    (halt),
		.req_n        (req_n),
		.gate_n       (gate_n)
	);

	// Converter stand-in answers each start three cycles later; counters
	// tally starts and scan pulses for the per-conversion checks
	always @(posedge ref_clk)
	begin
		busy_ff   <= {busy_ff[0], conv_start_ff};
		adc_done  <= busy_ff[1];
		scan_d_ff <= conv_pulse_out_ff;
		if (conv_start_ff) n_conv++;
		if (conv_pulse_out_ff && !scan_d_ff) n_scan++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 chk(reg_rdata_ff, exp);
	endtask

	// Bounded wait for one monitored level
	task automatic wt(input int s);
		for (int i = 0; i < 12; i++)
		begin
			@(posedge ref_clk);
			#1;
			if (mon[s] === 1'b1) break;
		end
	endtask

	// One request edge; expect exp starts and exp scan pulses
	task automatic conv(input int exp);
		int n0;
		int s0;
		n0 = n_conv;
		s0 = n_scan;
		fx.drive(2, 1'b0);
		fx.drive(2, 1'b1);
		repeat (8) @(posedge ref_clk);
		#1 chk(n_conv - n0, exp);
		chk(n_scan - s0, exp);
	endtask

	task automatic t_reset();
		#1 chk({user_strobe_n_ff, conv_start_ff, conv_pulse_out_ff,
			sense_to_ground_ff, acq_active_ff, acq_post_ff}, 6'h20);
		rd(atio_pkg::ADDR_CTRL, 32'h0);
		rd(4'h1, 32'h0);
		rd(atio_pkg::ADDR_STATUS, 32'h19);
	endtask

	task automatic t_strobe();
		wr(atio_pkg::ADDR_STROBE, 32'h0);
		for (int i = 0; i < atio_pkg::STROBE_CYCLES; i++)
		begin
			#1 chk(user_strobe_n_ff, 1'b0);
			@(posedge ref_clk);
		end
		#1 chk(user_strobe_n_ff, 1'b1);
	endtask

	task automatic t_sense();
		wr(atio_pkg::ADDR_CTRL, 32'h8);
		@(posedge ref_clk);
		#1 chk(sense_to_ground_ff, 1'b1);
		wr(atio_pkg::ADDR_CTRL, 32'h0);
		@(posedge ref_clk);
		#1 chk(sense_to_ground_ff, 1'b0);
	endtask

	task automatic t_post();
		conv(0);
		wr(atio_pkg::ADDR_CTRL, 32'h6);
		fx.drive(0, 1'b0);
		repeat (2) @(posedge ref_clk);
		#1 chk(acq_active_ff, 1'b0);
		fx.drive(0, 1'b1);
		wt(1);
		chk({acq_active_ff, acq_post_ff}, 2'h3);
		fx.drive(2, 1'b0);
		wt(2);
		@(posedge ref_clk);
		#1 chk(conv_pulse_out_ff, 1'b1);
		@(posedge ref_clk);
		#1 chk(conv_pulse_out_ff, 1'b0);
		fx.drive(2, 1'b1);
		conv(1);
		fx.drive(3, 1'b0);
		conv(0);
		fx.drive(3, 1'b1);
		rd(atio_pkg::ADDR_CONVCNT, 32'h2);
		wr(atio_pkg::ADDR_CTRL, 32'h0);
		conv(0);
		chk(acq_active_ff, 1'b0);
	endtask

	task automatic t_pre();
		int n0;
		wr(atio_pkg::ADDR_CTRL, 32'h7);
		fx.drive(0, 1'b0);
		fx.drive(0, 1'b1);
		wt(0);
		chk({acq_active_ff, acq_post_ff}, 2'h2);
		conv(1);
		// Software convert runs while the request rests high
		n0 = n_conv;
		wr(atio_pkg::ADDR_CTRL, 32'h15);
		repeat (8) @(posedge ref_clk);
		#1 chk(n_conv - n0, 1);
		// A request held low blocks the software convert
		fx.drive(2, 1'b0);
		repeat (8) @(posedge ref_clk);
		n0 = n_conv;
		wr(atio_pkg::ADDR_CTRL, 32'h15);
		repeat (8) @(posedge ref_clk);
		#1 chk(n_conv - n0, 0);
		fx.drive(2, 1'b1);
		fx.drive(1, 1'b1);
		fx.drive(1, 1'b0);
		wt(1);
		chk({acq_active_ff, acq_post_ff}, 2'h3);
		conv(1);
		wr(atio_pkg::ADDR_CTRL, 32'h0);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_strobe();
		t_sense();
		t_post();
		t_pre();
		give_verdict();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#200us;
		miscompares++;
		give_verdict();
	end
endmodule
